// [core/msisr_consts.vh]
// constants for the master selector interrupt status and reset-default block
// assumes a single 100 MHz clock domain and the protocol engine on the same clock
//
// Function
// - pointer 10 selects the status byte
// - one status copy per upstream master
// - bit 0 follows downstream interrupt input
// - bit 1 set when recovery finished, connected
// - bit 2 bus busy at switch, unless recovery
// - bit 3 set for master losing control
// - bit 6 follows own self-test bit
// - bit 7 follows other master's cross-test bit
// - status read-only, resets to zero, all variants
// - read leaves test and input flags alone
// - read clears bits 1-3 on second scl
// - input still low re-raises unmasked interrupt
// - test interrupt drops when test bit cleared
// - power-on release loads defaults and variant connection
// - channel-0 variant connects channel 0 immediately
// - stop variant connects channel 0 after stop
// - channel 1 switch connects on its stop
// - no-default variant connects nothing after reset
// - control write overrides variant default connection
// - external low reset holds all defaults
// - external reset, stop variant waits for stop
// - mask bit one blocks that event's interrupt
// - lost interrupt right after disconnection
`ifndef MSISR_CONSTS_VH
`define MSISR_CONSTS_VH

// register pointer value of the status register
`define MSISR_PTR_STATUS    2'h2

// status bit positions
`define MSISR_BIT_DS_IRQ    0
`define MSISR_BIT_REC_DONE  1
`define MSISR_BIT_NOT_IDLE  2
`define MSISR_BIT_LOST      3
`define MSISR_BIT_SELF      6
`define MSISR_BIT_CROSS     7
`define MSISR_STATUS_RESET  8'h00

// build variants
`define MSISR_VAR_CH0       2'h1
`define MSISR_VAR_STOP      2'h2
`define MSISR_VAR_NONE      2'h3

// downstream connection codes, one bit per upstream channel
`define MSISR_CONN_NONE     2'h0
`define MSISR_CONN_CH0      2'h1
`define MSISR_CONN_CH1      2'h2

// scl rising edge of the read data phase on which the clear lands
`define MSISR_CLR_EDGE      2'h2

`endif

// [core/msisr_core.v]
// interrupt status registers, interrupt outputs and default channel connection
// assumes the protocol engine on i_clk supplies pointers, read phase, control writes
`timescale 1ns/1ps
`include "msisr_consts.vh"

module msisr_core #(
    parameter [1:0] VARIANT = `MSISR_VAR_CH0
) (
    input  wire       i_clk,
    input  wire       i_sys_rst,
    input  wire       i_reset_n,
    input  wire       i_scl0,
    input  wire       i_sda0,
    input  wire       i_scl1,
    input  wire       i_sda1,
    input  wire       i_downstream_irq_n,
    input  wire [1:0] i_register_pointer0,
    input  wire [1:0] i_register_pointer1,
    input  wire [1:0] i_read_phase,
    input  wire       i_ctrl_write,
    input  wire [1:0] i_ctrl_target,
    input  wire       i_recovery_request,
    input  wire       i_recovery_done,
    input  wire       i_bus_busy,
    input  wire [1:0] i_self_test_request,
    input  wire [1:0] i_cross_test_request,
    input  wire [1:0] i_downstream_irq_mask,
    input  wire [1:0] i_recovery_done_mask,
    input  wire [1:0] i_bus_not_idle_mask,
    input  wire [1:0] i_control_lost_mask,
    output reg  [7:0] o_read_data0,
    output reg  [7:0] o_read_data1,
    output reg  [1:0] o_connect,
    output reg        o_recovery_start,
    output wire       o_master0_irq_output_n,
    output wire       o_master0_irq_output_oe,
    output wire       o_master1_irq_output_n,
    output wire       o_master1_irq_output_oe
);

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    // six asynchronous pins share one filter: upstream clock and data of both
    // masters, the external reset and the downstream interrupt; all idle high,
    // so every stage resets to one and no false edge or stop follows reset
    localparam NPIN = 6;

    wire [NPIN-1:0] pin_raw;
    wire [NPIN-1:0] pin_lvl;
    wire [NPIN-1:0] pin_prev;

    assign pin_raw = {i_downstream_irq_n, i_reset_n, i_sda1, i_scl1, i_sda0, i_scl0};

    // three stages; the filtered level only moves once stages two and three agree,
    // which costs about four cycles of latency but rejects a one-cycle glitch
    genvar gp;
    generate
        for (gp = 0; gp < NPIN; gp = gp + 1) begin : g_pin
            reg s1;
            reg s2;
            reg s3;
            reg lvl;
            reg prev;

            always @(posedge i_clk or posedge i_sys_rst) begin
                if (i_sys_rst) begin
                    s1   <= 1'b1;
                    s2   <= 1'b1;
                    s3   <= 1'b1;
                    lvl  <= 1'b1;
                    prev <= 1'b1;
                end else begin
                    s1   <= pin_raw[gp];
                    s2   <= s1;
                    s3   <= s2;
                    prev <= lvl;
                    if (s2 == s3) begin
                        lvl <= s3;
                    end
                end
            end

            // filtered level and its value one cycle back feed the edge finders
            assign pin_lvl[gp]  = lvl;
            assign pin_prev[gp] = prev;
        end
    endgenerate

    // pin map: 0 scl0, 1 sda0, 2 scl1, 3 sda1, 4 external reset, 5 downstream interrupt
    wire [1:0] scl_lvl;
    wire [1:0] scl_rise;
    wire [1:0] stop_seen;
    wire       ext_hold;
    wire       ds_irq_active;

    assign scl_lvl       = {pin_lvl[2], pin_lvl[0]};
    // rising clock edges per master count the read-clear pulses
    assign scl_rise      = {pin_lvl[2] & ~pin_prev[2], pin_lvl[0] & ~pin_prev[0]};
    // stop: sda rises while scl stays high
    assign stop_seen     = {pin_lvl[3] & ~pin_prev[3] & scl_lvl[1] & pin_prev[2],
                            pin_lvl[1] & ~pin_prev[1] & scl_lvl[0] & pin_prev[0]};
    // a low reset pin holds everything at its defaults, not just the flags
    assign ext_hold      = ~pin_lvl[4];
    assign ds_irq_active = ~pin_lvl[5];

    ////////////////////////////////////////////////////////////////////////////
    // connection sequencer

    // idle: connection stands, a control write arms a switch
    // switch wait: the switch happens at the next stop on the target channel
    // recovery: old link broken, new one held off until the pulse train is done
    // the recovery path never reports a busy bus, the sensor result is moot there
    localparam [1:0] ST_IDLE     = 2'h0;
    localparam [1:0] ST_SW_WAIT  = 2'h1;
    localparam [1:0] ST_RECOVERY = 2'h2;

    // power-up connection: only the channel-0 variant joins at once; the stop
    // variant waits in ch0_pending and the no-default variant stays open
    localparam [1:0] CONN_DEFAULT = (VARIANT == `MSISR_VAR_CH0) ? `MSISR_CONN_CH0 : `MSISR_CONN_NONE;

    reg  [1:0] state;
    reg  [1:0] next_state;
    reg  [1:0] target;
    reg        ch0_pending;
    reg        override;
    reg  [1:0] next_connect;
    reg  [1:0] next_target;
    reg        next_ch0_pending;
    reg        next_override;
    reg        next_recovery_start;
    reg  [1:0] ev_lost;
    reg  [1:0] ev_not_idle;
    reg  [1:0] ev_rec_done;

    // switch request waits for the stop closing the control write, then breaks
    // the old link in the cycle the new one is made, or before recovery, so the losing master never shares the bus
    always @* begin
        next_state          = state;
        next_connect        = o_connect;
        next_target         = target;
        next_ch0_pending    = ch0_pending;
        next_override       = override;
        next_recovery_start = 1'b0;
        ev_lost             = 2'h0;
        ev_not_idle         = 2'h0;
        ev_rec_done         = 2'h0;
        // stop variant default: channel 0 joins at its first stop
        if (ch0_pending && !override && stop_seen[0]) begin
            next_connect     = `MSISR_CONN_CH0;
            next_ch0_pending = 1'b0;
        end
        case (state)
            ST_IDLE: begin
                // any write decides the connection from now on
                if (i_ctrl_write) begin
                    next_override = 1'b1;
                    next_target   = i_ctrl_target;
                    next_state    = ST_SW_WAIT;
                end
            end
            ST_SW_WAIT: begin
                if (i_ctrl_write) begin
                    next_target = i_ctrl_target;
                end else if (|(stop_seen & target) || (target == `MSISR_CONN_NONE && |stop_seen)) begin
                    next_ch0_pending = 1'b0;
                    // a write that names the present connection keeps the link and raises no flag
                    if (target == o_connect) begin
                        next_state = ST_IDLE;
                    end else begin
                        ev_lost      = o_connect;
                        // break before make on the recovery path only: the old master loses the bus in this cycle
                        next_connect = `MSISR_CONN_NONE;
                        if (i_recovery_request && target != `MSISR_CONN_NONE) begin
                            next_recovery_start = 1'b1;
                            next_state          = ST_RECOVERY;
                        end else begin
                            next_connect = target;
                            ev_not_idle  = i_bus_busy ? target : 2'h0;
                            next_state   = ST_IDLE;
                        end
                    end
                end
            end
            ST_RECOVERY: begin
                // the not-idle report stays quiet on this path by construction
                // a control write here is ignored; the pulse train must finish first
                if (i_recovery_done) begin
                    next_connect = target;
                    ev_rec_done  = target;
                    next_state   = ST_IDLE;
                end
            end
            default: begin
                // unused code: fall back to idle
                next_state = ST_IDLE;
            end
        endcase
    end

    // power-on and external reset load the same variant defaults
    // the pin reset acts after the filter, so a one-cycle low glitch on it
    // never disturbs a running switch
    always @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state            <= ST_IDLE;
            o_connect        <= CONN_DEFAULT;
            target           <= `MSISR_CONN_NONE;
            ch0_pending      <= (VARIANT == `MSISR_VAR_STOP);
            override         <= 1'b0;
            o_recovery_start <= 1'b0;
        end else if (ext_hold) begin
            state            <= ST_IDLE;
            o_connect        <= CONN_DEFAULT;
            target           <= `MSISR_CONN_NONE;
            ch0_pending      <= (VARIANT == `MSISR_VAR_STOP);
            override         <= 1'b0;
            o_recovery_start <= 1'b0;
        end else begin
            state            <= next_state;
            o_connect        <= next_connect;
            target           <= next_target;
            ch0_pending      <= next_ch0_pending;
            override         <= next_override;
            o_recovery_start <= next_recovery_start;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // per-master status registers

    // two physical copies of the status byte, one per upstream master; flags
    // that record events are set by the sequencer and cleared by a read, the
    // others mirror a level and ignore reads
    wire [1:0] ptr_status;
    wire [1:0] irq_active;
    wire [7:0] status0;
    wire [7:0] status1;

    assign ptr_status = {i_register_pointer1 == `MSISR_PTR_STATUS,
                         i_register_pointer0 == `MSISR_PTR_STATUS};

    genvar gm;
    generate
        for (gm = 0; gm < 2; gm = gm + 1) begin : g_master
            reg  [1:0] clr_cnt;
            reg        rec_done_flag;
            reg        not_idle_flag;
            reg        lost_flag;
            reg        ds_flag;
            reg        self_flag;
            reg        cross_flag;
            wire       clr_hit;
            reg  [7:0] status;
            reg  [7:0] mask;

            // clear lands on the second scl rise of this master's status read
            // the counter restarts whenever the read phase or the pointer drops, so an
            // aborted read never carries a half count into the next one
            assign clr_hit = i_read_phase[gm] & ptr_status[gm] & scl_rise[gm]
                             & (clr_cnt == `MSISR_CLR_EDGE - 2'h1);

            always @(posedge i_clk or posedge i_sys_rst) begin
                if (i_sys_rst) begin
                    clr_cnt       <= 2'h0;
                    rec_done_flag <= 1'b0;
                    not_idle_flag <= 1'b0;
                    lost_flag     <= 1'b0;
                    ds_flag       <= 1'b0;
                    self_flag     <= 1'b0;
                    cross_flag    <= 1'b0;
                end else if (ext_hold) begin
                    clr_cnt       <= 2'h0;
                    rec_done_flag <= 1'b0;
                    not_idle_flag <= 1'b0;
                    lost_flag     <= 1'b0;
                    ds_flag       <= 1'b0;
                    self_flag     <= 1'b0;
                    cross_flag    <= 1'b0;
                end else begin
                    if (!(i_read_phase[gm] && ptr_status[gm])) begin
                        clr_cnt <= 2'h0;
                    end else if (scl_rise[gm] && clr_cnt != `MSISR_CLR_EDGE) begin
                        clr_cnt <= clr_cnt + 2'h1;
                    end
                    // a new event in the clearing cycle wins over the clear,
                    // so a switch that lands during a read is never lost
                    rec_done_flag <= ev_rec_done[gm] | (rec_done_flag & ~clr_hit);
                    not_idle_flag <= ev_not_idle[gm] | (not_idle_flag & ~clr_hit);
                    lost_flag     <= ev_lost[gm] | (lost_flag & ~clr_hit);
                    // level-following flags; a read does not touch them
                    // the downstream flag waits for the pin filter, the test flags one cycle
                    ds_flag       <= ds_irq_active;
                    self_flag     <= i_self_test_request[gm];
                    cross_flag    <= i_cross_test_request[1-gm];
                end
            end

            // status byte from the named bit positions; the two spare bits read zero
            // and the test bits have no mask, they exist to prove the wire works
            always @* begin
                status                      = `MSISR_STATUS_RESET;
                status[`MSISR_BIT_DS_IRQ]   = ds_flag;
                status[`MSISR_BIT_REC_DONE] = rec_done_flag;
                status[`MSISR_BIT_NOT_IDLE] = not_idle_flag;
                status[`MSISR_BIT_LOST]     = lost_flag;
                status[`MSISR_BIT_SELF]     = self_flag;
                status[`MSISR_BIT_CROSS]    = cross_flag;
                mask                        = 8'h00;
                mask[`MSISR_BIT_DS_IRQ]     = i_downstream_irq_mask[gm];
                mask[`MSISR_BIT_REC_DONE]   = i_recovery_done_mask[gm];
                mask[`MSISR_BIT_NOT_IDLE]   = i_bus_not_idle_mask[gm];
                mask[`MSISR_BIT_LOST]       = i_control_lost_mask[gm];
            end

            // any unmasked flag pulls this master's line low
            assign irq_active[gm] = |(status & ~mask);
        end
    endgenerate

    assign status0 = g_master[0].status;
    assign status1 = g_master[1].status;

    // each master sees only its own copy
    // registered every cycle one cycle behind the flags, so the byte can still change inside a bit time;
    // another pointer reads zero here, the other registers live elsewhere
    always @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_read_data0 <= `MSISR_STATUS_RESET;
            o_read_data1 <= `MSISR_STATUS_RESET;
        end else begin
            o_read_data0 <= ptr_status[0] ? status0 : `MSISR_STATUS_RESET;
            o_read_data1 <= ptr_status[1] ? status1 : `MSISR_STATUS_RESET;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // open-drain interrupt outputs: drive low only, release otherwise
    // the data pin is tied low and only the enable moves, so the line is never
    // driven high against the wired pull-up

    assign o_master0_irq_output_n  = 1'b0;
    assign o_master0_irq_output_oe = irq_active[0];
    assign o_master1_irq_output_n  = 1'b0;
    assign o_master1_irq_output_oe = irq_active[1];

endmodule

// [verif/msisr_checker.sv]
// concurrent checks on the ports of the interrupt status and reset-default block
// assumes one i_clk domain and the active-high asynchronous i_sys_rst
`timescale 1ns/1ps

module msisr_checker #(
    parameter [1:0] VARIANT = 2'h1
) (
    input wire       i_clk,
    input wire       i_sys_rst,
    input wire       i_reset_n,
    input wire       i_downstream_irq_n,
    input wire [1:0] i_register_pointer0,
    input wire [1:0] i_self_test_request,
    input wire [1:0] i_cross_test_request,
    input wire [1:0] i_downstream_irq_mask,
    input wire [7:0] o_read_data0,
    input wire [1:0] o_connect,
    input wire       o_master0_irq_output_oe,
    input wire       o_master1_irq_output_oe
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    ////////////////////////////////////////////////////////////////////////////////
    // steps: eight cycles cover the pin synchroniser plus flag and read-data registers
    sequence s_ext_hold;
        !i_reset_n [*8];
    endsequence
    sequence s_ds_low;
        (!i_downstream_irq_n && i_reset_n && i_register_pointer0 == 2'h2) [*8];
    endsequence

    property p_ptr; i_register_pointer0 != 2'h2 |=> o_read_data0 == 8'h00; endproperty
    property p_self; (i_self_test_request[0] && i_reset_n && i_register_pointer0 == 2'h2) [*8] |-> o_read_data0[6];
    endproperty
    property p_cross; (i_cross_test_request[1] && i_reset_n && i_register_pointer0 == 2'h2) [*8] |-> o_read_data0[7];
    endproperty
    property p_test_oe; (i_self_test_request[1] && i_reset_n) [*8] |-> o_master1_irq_output_oe; endproperty
    property p_ds_bit; s_ds_low |-> o_read_data0[0]; endproperty
    property p_ds_oe; (!i_downstream_irq_n && !i_downstream_irq_mask[0] && i_reset_n) [*8] |-> o_master0_irq_output_oe;
    endproperty
    // first edge after power-on release shows the variant's default connection and no master-0 interrupt
    property p_por; $fell(i_sys_rst) |-> o_connect == (VARIANT == 2'h1 ? 2'h1 : 2'h0) && !o_master0_irq_output_oe;
    endproperty
    property p_ext; s_ext_hold |-> o_connect == (VARIANT == 2'h1 ? 2'h1 : 2'h0) && o_read_data0 == 8'h00;
    endproperty

    a_ptr: assert property (p_ptr) else $error("status byte seen with another pointer");
    a_self: assert property (p_self) else $error("self test flag missing");
    a_cross: assert property (p_cross) else $error("cross test flag missing");
    a_test_oe: assert property (p_test_oe) else $error("test interrupt not driven");
    a_ds_bit: assert property (p_ds_bit) else $error("downstream flag missing");
    a_ds_oe: assert property (p_ds_oe) else $error("downstream interrupt not driven");
    a_por: assert property (p_por) else $error("wrong state after power-on release");
    a_ext: assert property (p_ext) else $error("external reset not holding defaults");
endmodule

// [verif/msisr_master_model.sv]
// one upstream bus master seen as its clock and data pins
// assumes pull-ups: both lines idle high and the clock stands still outside frames
`timescale 1ns/1ps

module msisr_master_model;
    reg scl = 1'b1;
    reg sda = 1'b1;

    ////////////////////////////////////////////////////////////////////////////////
    // clock pulses at a 125 ns period; the small lead keeps edges off the system clock
    task clocks(input integer n);
        #2;
        repeat (n) begin
            #62.5 scl = 1'b0;
            #62.5 scl = 1'b1;
        end
    endtask

    // data rises while the clock is high: the stop that completes a switch
    task stop;
        #2;
        #31.25 scl = 1'b0;
        #31.25 sda = 1'b0;
        #31.25 scl = 1'b1;
        #31.25 sda = 1'b1;
    endtask
endmodule

// [verif/master_selector_irq_status_reset_test.sv]
// self-checking bench for the interrupt status and reset-default block, stop-detect build
// assumes the constants header on the include path and two master models as far side
`timescale 1ns/1ps
`include "msisr_consts.vh"

module master_selector_irq_status_reset_test;
    reg        i_clk = 1'b0;
    reg        i_sys_rst, i_reset_n, ds_n, ctrl_write, rec_req, rec_done, busy;
    reg        rec_seen = 1'b0;
    reg  [1:0] ptr0, ptr1, ctrl_target, self_req, cross_req, m_ds, m_rec, m_idle, m_lost, rph;
    wire [7:0] rd0, rd1;
    wire [1:0] conn;
    wire       rec_start, oe0, oe1, n0, n1;
    integer    error_cnt = 0;
    integer    checked = 0;
    integer    cycles = 0;

    msisr_master_model i_m0();
    msisr_master_model i_m1();

    msisr_core #(.VARIANT(`MSISR_VAR_STOP)) i_dut (
        .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_reset_n(i_reset_n),
        .i_scl0(i_m0.scl), .i_sda0(i_m0.sda), .i_scl1(i_m1.scl), .i_sda1(i_m1.sda),
        .i_downstream_irq_n(ds_n), .i_register_pointer0(ptr0), .i_register_pointer1(ptr1),
        .i_read_phase(rph), .i_ctrl_write(ctrl_write), .i_ctrl_target(ctrl_target),
        .i_recovery_request(rec_req), .i_recovery_done(rec_done), .i_bus_busy(busy),
        .i_self_test_request(self_req), .i_cross_test_request(cross_req),
        .i_downstream_irq_mask(m_ds), .i_recovery_done_mask(m_rec), .i_bus_not_idle_mask(m_idle),
        .i_control_lost_mask(m_lost), .o_read_data0(rd0), .o_read_data1(rd1), .o_connect(conn),
        .o_recovery_start(rec_start), .o_master0_irq_output_n(n0), .o_master0_irq_output_oe(oe0),
        .o_master1_irq_output_n(n1), .o_master1_irq_output_oe(oe1));

    ////////////////////////////////////////////////////////////////////////////////
    // clock, hang guard, and a latch for the one-cycle recovery start pulse
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        if (rec_start)
            rec_seen <= 1'b1;
        if (cycles == 5000) begin
            error_cnt = error_cnt + 1;
            summarize;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task step(input integer n);
        repeat (n) @(negedge i_clk);
    endtask
    task chk(input [7:0] got, input [7:0] exp, input string what);
        checked = checked + 1;
        if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    // status read phase with n clock rises from master m; the clear needs the second rise
    task read_clear(input integer m, input integer n);
        rph = 2'h1 << m;
        if (m == 0)
            i_m0.clocks(n);
        else
            i_m1.clocks(n);
        step(10);
        rph = 2'h0;
        step(2);
    endtask
    task switch_to(input [1:0] target);
        ctrl_target = target;
        ctrl_write = 1'b1;
        step(1);
        ctrl_write = 1'b0;
    endtask
    task summarize;
        $display("errors %0d of %0d checks", error_cnt, checked);
        if (error_cnt == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence: reset defaults, test flags, downstream input, switch, recovery, pin reset
    initial begin
        i_sys_rst = 1'b1;
        {i_reset_n, ds_n, ctrl_write, rec_req, rec_done, busy} = 6'h30;
        {ptr0, ptr1, ctrl_target, self_req, cross_req, m_ds, m_rec, m_idle, m_lost, rph} = {4'ha, 16'h0};
        step(10);
        i_sys_rst = 1'b0;
        step(6);
        chk({6'h0, conn}, 8'h00, "conn after reset");
        chk(rd1, `MSISR_STATUS_RESET, "status reset");
        i_m0.stop();
        step(10);
        chk({6'h0, conn}, 8'h01, "conn ch0 on stop");
        self_req = 2'h1;
        cross_req = 2'h1;
        step(4);
        chk(rd0, 8'h40, "self test");
        chk(rd1, 8'h80, "cross test");
        chk({6'h0, oe0, oe1}, 8'h03, "test irq");
        chk({6'h0, n0, n1}, 8'h00, "open-drain data low");
        ptr0 = 2'h1;
        step(3);
        chk(rd0, 8'h00, "other pointer");
        ptr0 = 2'h2;
        read_clear(0, 2);
        chk(rd0, 8'h40, "test flag kept");
        self_req = 2'h2;
        cross_req = 2'h2;
        step(9);
        chk(rd0, 8'h80, "cross test from master1");
        chk(rd1, 8'h40, "self test master1");
        self_req = 2'h0;
        cross_req = 2'h0;
        step(4);
        chk({6'h0, oe0, oe1}, 8'h00, "test cleared");
        ds_n = 1'b0;
        m_ds = 2'h2;
        step(10);
        chk(rd1, 8'h01, "downstream flag");
        chk({6'h0, oe0, oe1}, 8'h02, "downstream irq mask");
        read_clear(0, 2);
        chk(rd0, 8'h01, "downstream kept");
        chk({7'h0, oe0}, 8'h01, "downstream irq again");
        ds_n = 1'b1;
        m_ds = 2'h0;
        step(10);
        chk(rd0, 8'h00, "downstream gone");
        busy = 1'b1;
        switch_to(`MSISR_CONN_CH1);
        i_m1.stop();
        step(10);
        chk({6'h0, conn}, 8'h02, "conn ch1");
        chk(rd0, 8'h08, "lost flag");
        chk(rd1, 8'h04, "not idle flag");
        chk({6'h0, oe0, oe1}, 8'h03, "switch irq");
        m_lost = 2'h1;
        step(2);
        chk({7'h0, oe0}, 8'h00, "lost masked");
        m_lost = 2'h0;
        read_clear(1, 1);
        chk(rd1, 8'h04, "one pulse keeps flag");
        read_clear(1, 2);
        chk(rd1, 8'h00, "not idle cleared");
        chk(rd0, 8'h08, "other copy kept");
        read_clear(0, 2);
        chk(rd0, 8'h00, "lost cleared");
        rec_req = 1'b1;
        switch_to(`MSISR_CONN_CH0);
        i_m0.stop();
        step(10);
        chk({6'h0, conn}, 8'h00, "recovery wait");
        chk({7'h0, rec_seen}, 8'h01, "recovery start");
        rec_done = 1'b1;
        step(1);
        rec_done = 1'b0;
        step(3);
        chk({6'h0, conn}, 8'h01, "conn after recovery");
        chk(rd0, 8'h02, "recovery flag only");
        chk(rd1, 8'h08, "lost for master1");
        i_reset_n = 1'b0;
        step(10);
        chk({6'h0, conn}, 8'h00, "pin reset conn");
        chk(rd1, 8'h00, "pin reset status");
        i_reset_n = 1'b1;
        rec_req = 1'b0;
        step(8);
        i_m0.stop();
        step(10);
        chk({6'h0, conn}, 8'h01, "stop after pin reset");
        summarize;
    end
endmodule

bind msisr_core msisr_checker #(.VARIANT(VARIANT)) i_chk (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_reset_n(i_reset_n), .i_downstream_irq_n(i_downstream_irq_n),
    .i_register_pointer0(i_register_pointer0), .i_self_test_request(i_self_test_request),
    .i_cross_test_request(i_cross_test_request), .i_downstream_irq_mask(i_downstream_irq_mask),
    .o_read_data0(o_read_data0), .o_connect(o_connect),
    .o_master0_irq_output_oe(o_master0_irq_output_oe), .o_master1_irq_output_oe(o_master1_irq_output_oe));
